// *** include/pd2g_params.svh ***
`ifndef PD2G_PARAMS_SVH
`define PD2G_PARAMS_SVH

// register addresses on the serial configuration port
`define PD2G_ADDR_W        7
`define PD2G_ADDR_PLL2     7'h6C
`define PD2G_ADDR_PLL1     7'h6D

// register width, reset value and writable bits (bit 3 unused)
`define PD2G_DATA_W        8
`define PD2G_RESET_VAL     8'hC2
`define PD2G_WRITE_MASK    8'hF7
`define PD2G_ZERO_BYTE     8'h00

// field positions inside each gain register
`define PD2G_AUTO_BIT      7
`define PD2G_ANA_HI        6
`define PD2G_ANA_LO        4
`define PD2G_DIG_HI        2
`define PD2G_DIG_LO        0
`define PD2G_GAIN_W        3
`define PD2G_ZERO_GAIN     3'h0

// index of each pll in the register array
`define PD2G_NUM_PLL       2
`define PD2G_IDX_PLL1      1'h0
`define PD2G_IDX_PLL2      1'h1

`endif

// *** include/pd2g_pkg.sv ***
package pd2g_pkg;

    // loop feedback mode reported by the pll datapath
    typedef enum logic {
        PD2G_FB_DIGITAL,
        PD2G_FB_ANALOG
    } pd2g_fb_mode_t;

    // phase detector gain code
    typedef logic [2:0] pd2g_gain_t;

endpackage : pd2g_pkg

// *** verilog/pd2g_gain_sel.sv ***
`timescale 1ns/1ps
`include "pd2g_params.svh"

module pd2g_gain_sel
    import pd2g_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          auto_en,      // automatic selection enable
    input  wire pd2g_gain_t    analog_gain,  // gain for analog feedback
    input  wire pd2g_gain_t    digital_gain, // gain for digital feedback
    input  wire pd2g_fb_mode_t fb_mode,      // current feedback mode
    input  wire logic          ref_above_8k, // reference faster than 8 kHz
    output logic [2:0]         gain_q,       // applied detector gain
    output logic               in_use_q      // this gain set is in use
);

    logic [2:0] gain_d;    // next applied gain
    logic       in_use_d;  // next in-use flag

    // choose the detector gain from the fields and the loop state
    always_comb begin
        gain_d   = digital_gain;
        in_use_d = 1'b1;
        if (!auto_en) begin
            // selection off: digital field always applies
            gain_d   = digital_gain; // RULE2
            in_use_d = 1'b1;
        end else if (fb_mode == PD2G_FB_DIGITAL) begin
            // digital feedback lock
            gain_d   = digital_gain; // RULE1 RULE5
            in_use_d = 1'b1;
        end else if (ref_above_8k) begin
            // analog feedback on a fast reference
            gain_d   = analog_gain; // RULE5
            in_use_d = 1'b1;
        end else begin
            // slow analog reference: another gain set governs
            gain_d   = `PD2G_ZERO_GAIN;
            in_use_d = 1'b0;
        end
    end

    // register the selection
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gain_q   <= `PD2G_ZERO_GAIN;
            in_use_q <= 1'b0;
        end else begin
            gain_q   <= gain_d;
            in_use_q <= in_use_d;
        end
    end

    sequence sel_off_s;
        !auto_en;
    endsequence

    sequence sel_dig_s;
        auto_en && fb_mode == PD2G_FB_DIGITAL;
    endsequence

    sequence sel_ana_s;
        auto_en && fb_mode == PD2G_FB_ANALOG && ref_above_8k;
    endsequence

    manual_gain_a: assert property ( // RULE2
        @(posedge clk) disable iff (reset)
        sel_off_s |=> in_use_q && gain_q == $past(digital_gain))
        else $error("manual mode did not apply digital gain");

    digital_gain_a: assert property ( // RULE1
        @(posedge clk) disable iff (reset)
        sel_dig_s |=> in_use_q && gain_q == $past(digital_gain))
        else $error("digital feedback gain not applied");

    analog_gain_a: assert property ( // RULE5
        @(posedge clk) disable iff (reset)
        sel_ana_s |=> in_use_q && gain_q == $past(analog_gain))
        else $error("analog feedback gain not applied");

    slow_ref_a: assert property ( // RULE5
        @(posedge clk) disable iff (reset)
        (auto_en && fb_mode == PD2G_FB_ANALOG && !ref_above_8k)
            |=> !in_use_q)
        else $error("gain set used on slow analog reference");

endmodule : pd2g_gain_sel

// *** verilog/pd2g_regs.sv ***
`timescale 1ns/1ps
`include "pd2g_params.svh"

// Notes on behaviour
// (RULE1) second pll digital field sets digital-mode gain
// (RULE2) selection off: digital field always applies
// (RULE3) second pll register read/write, resets to C2
// (RULE4) first pll register alike, resets to C2
// (RULE5) auto: analog field above 8 kHz; bit3 zero
module pd2g_regs
    import pd2g_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic [6:0]    reg_addr,
    input  wire logic          reg_wr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_rd,
    output logic [7:0]         reg_rdata,
    input  wire pd2g_fb_mode_t pll1_fb_mode,
    input  wire logic          pll1_ref_above_8k,
    input  wire pd2g_fb_mode_t pll2_fb_mode,
    input  wire logic          pll2_ref_above_8k,
    output logic               pll1_auto_gain_select_en,
    output logic [2:0]         pll1_analog_fb_gain,
    output logic [2:0]         pll1_digital_fb_gain,
    output logic               pll2_auto_gain_select_en,
    output logic [2:0]         pll2_analog_fb_gain,
    output logic [2:0]         pll2_digital_fb_gain,
    output logic [2:0]         pll1_applied_gain,
    output logic               pll1_gain_in_use,
    output logic [2:0]         pll2_applied_gain,
    output logic               pll2_gain_in_use
);

    // address decode: bit 1 hit, bit 0 register index
    function automatic logic [1:0] reg_decode(input logic [6:0] addr);
        logic [1:0] res;
        res = 2'h0;
        unique case (addr)
            `PD2G_ADDR_PLL1: res = {1'b1, `PD2G_IDX_PLL1};
            `PD2G_ADDR_PLL2: res = {1'b1, `PD2G_IDX_PLL2};
            default:         res = 2'h0;
        endcase
        return res;
    endfunction : reg_decode

    logic [7:0] cfg_q [`PD2G_NUM_PLL]; // gain registers, 0 first pll
    logic [7:0] cfg_d [`PD2G_NUM_PLL]; // next register values
    logic [7:0] rdata_q;               // read data holding register
    logic [7:0] rdata_d;               // next read data
    logic [1:0] wr_dec;                // decode of the write address
    logic [1:0] rd_dec;                // decode of the read address

    pd2g_fb_mode_t fb_mode [`PD2G_NUM_PLL]; // per pll feedback mode
    logic          fast_ref [`PD2G_NUM_PLL]; // per pll reference rate
    logic [2:0]    gain_q  [`PD2G_NUM_PLL]; // applied gains
    logic          use_q   [`PD2G_NUM_PLL]; // gain set in use

    assign wr_dec = reg_decode(reg_addr);
    assign rd_dec = reg_decode(reg_addr);

    // per pll loop state into arrays
    assign fb_mode[0]  = pll1_fb_mode;
    assign fb_mode[1]  = pll2_fb_mode;
    assign fast_ref[0] = pll1_ref_above_8k;
    assign fast_ref[1] = pll2_ref_above_8k;

    // register write: one byte per access, bit 3 kept at zero
    always_comb begin
        for (int i = 0; i < `PD2G_NUM_PLL; i++) begin
            cfg_d[i] = cfg_q[i];
        end
        if (reg_wr && wr_dec[1]) begin
            // RULE3 RULE4 RULE5
            cfg_d[wr_dec[0]] = reg_wdata & `PD2G_WRITE_MASK;
        end
    end

    // read path: answer the next cycle, hold until the next read
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            if (rd_dec[1]) begin
                rdata_d = cfg_q[rd_dec[0]]; // RULE3 RULE4
            end else begin
                // unmapped address reads zero
                rdata_d = `PD2G_ZERO_BYTE;
            end
        end
    end

    // register state, reset to the documented default
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < `PD2G_NUM_PLL; i++) begin
                cfg_q[i] <= `PD2G_RESET_VAL; // RULE3 RULE4
            end
            rdata_q <= `PD2G_ZERO_BYTE;
        end else begin
            for (int i = 0; i < `PD2G_NUM_PLL; i++) begin
                cfg_q[i] <= cfg_d[i];
            end
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // gain selection for each pll
    generate
        for (genvar g = 0; g < `PD2G_NUM_PLL; g++) begin : gen_sel
            pd2g_gain_sel u_sel (
                .clk          (clk),
                .reset        (reset),
                .auto_en      (cfg_q[g][`PD2G_AUTO_BIT]),
                .analog_gain  (cfg_q[g][`PD2G_ANA_HI:`PD2G_ANA_LO]),
                .digital_gain (cfg_q[g][`PD2G_DIG_HI:`PD2G_DIG_LO]),
                .fb_mode      (fb_mode[g]),
                .ref_above_8k (fast_ref[g]),
                .gain_q       (gain_q[g]),
                .in_use_q     (use_q[g])
            );
        end
    endgenerate

    // field outputs straight from the register flops
    assign pll1_auto_gain_select_en = cfg_q[0][`PD2G_AUTO_BIT];
    assign pll1_analog_fb_gain      = cfg_q[0][`PD2G_ANA_HI:`PD2G_ANA_LO];
    assign pll1_digital_fb_gain     = cfg_q[0][`PD2G_DIG_HI:`PD2G_DIG_LO];
    assign pll2_auto_gain_select_en = cfg_q[1][`PD2G_AUTO_BIT];
    assign pll2_analog_fb_gain      = cfg_q[1][`PD2G_ANA_HI:`PD2G_ANA_LO];
    assign pll2_digital_fb_gain     = cfg_q[1][`PD2G_DIG_HI:`PD2G_DIG_LO];

    // applied gains from the selector flops
    assign pll1_applied_gain = gain_q[0];
    assign pll1_gain_in_use  = use_q[0];
    assign pll2_applied_gain = gain_q[1];
    assign pll2_gain_in_use  = use_q[1];

    sequence wr_pll2_s;
        reg_wr && reg_addr == `PD2G_ADDR_PLL2;
    endsequence

    sequence rd_pll2_s;
        reg_rd && !reg_wr && reg_addr == `PD2G_ADDR_PLL2;
    endsequence

    sequence wr_pll1_s;
        reg_wr && reg_addr == `PD2G_ADDR_PLL1;
    endsequence

    sequence rd_pll1_s;
        reg_rd && !reg_wr && reg_addr == `PD2G_ADDR_PLL1;
    endsequence

    reset_pll2_a: assert property ( // RULE3
        @(posedge clk) disable iff (reset)
        $fell(reset) |-> cfg_q[1] == `PD2G_RESET_VAL)
        else $error("second pll register reset value wrong");

    reset_pll1_a: assert property ( // RULE4
        @(posedge clk) disable iff (reset)
        $fell(reset) |-> cfg_q[0] == `PD2G_RESET_VAL
            && pll1_auto_gain_select_en)
        else $error("first pll register reset value wrong");

    readback_pll2_a: assert property ( // RULE3
        @(posedge clk) disable iff (reset)
        wr_pll2_s ##1 rd_pll2_s |=>
            reg_rdata == ($past(reg_wdata, 2) & `PD2G_WRITE_MASK))
        else $error("second pll register readback mismatch");

    readback_pll1_a: assert property ( // RULE4
        @(posedge clk) disable iff (reset)
        wr_pll1_s ##1 rd_pll1_s |=>
            reg_rdata == ($past(reg_wdata, 2) & `PD2G_WRITE_MASK))
        else $error("first pll register readback mismatch");

    unused_bit_a: assert property ( // RULE5
        @(posedge clk) disable iff (reset)
        reg_rd |=> (reg_rdata & ~`PD2G_WRITE_MASK) == `PD2G_ZERO_BYTE)
        else $error("unused bit 3 read as one");

    unmapped_read_a: assert property (
        @(posedge clk) disable iff (reset)
        (reg_rd && !rd_dec[1]) |=>
            reg_rdata == `PD2G_ZERO_BYTE)
        else $error("unmapped address returned data");

    pll2_digital_a: assert property ( // RULE1
        @(posedge clk) disable iff (reset)
        pll2_fb_mode == PD2G_FB_DIGITAL
            |=> pll2_applied_gain == $past(pll2_digital_fb_gain))
        else $error("second pll digital gain not applied");

    pll2_manual_a: assert property ( // RULE2
        @(posedge clk) disable iff (reset)
        !pll2_auto_gain_select_en
            |=> pll2_gain_in_use
            && pll2_applied_gain == $past(pll2_digital_fb_gain))
        else $error("second pll manual gain not applied");

endmodule : pd2g_regs

// *** verification/pd2g_regs_tb.sv ***
`timescale 1ns/1ps

module pd2g_regs_tb
    import pd2g_pkg::*;
;
    logic           clk;                // 250 MHz system clock
    logic           reset;              // async active-high reset
    logic [6:0]     reg_addr;           // register address
    logic           reg_wr;             // write strobe
    logic [7:0]     reg_wdata;          // write data
    logic           reg_rd;             // read strobe
    logic [7:0]     reg_rdata;          // registered read data
    pd2g_fb_mode_t  fb_mode;            // feedback mode, both plls
    logic           ref_fast;           // reference above 8 kHz, both plls
    logic           pll1_auto;          // first pll field outputs
    logic [2:0]     pll1_ana;
    logic [2:0]     pll1_dig;
    logic           pll2_auto;          // second pll field outputs
    logic [2:0]     pll2_ana;
    logic [2:0]     pll2_dig;
    logic [2:0]     pll1_gain;          // applied gains and in-use flags
    logic           pll1_use;
    logic [2:0]     pll2_gain;
    logic           pll2_use;
    int             failures;           // mismatch count
    int             checks;             // comparison count
    logic [7:0]     wval;               // value written in the loop
    logic [7:0]     exp_g;              // expected gain, zero extended
    logic           exp_u;              // expected in-use flag
    logic [7:0]     pll1_fields;        // first pll fields as one byte
    logic [7:0]     pll2_fields;        // second pll fields as one byte

    // field outputs packed in register layout, bit 3 zero
    assign pll1_fields = {pll1_auto, pll1_ana, 1'b0, pll1_dig};
    assign pll2_fields = {pll2_auto, pll2_ana, 1'b0, pll2_dig};

    // design under test, both plls share mode and reference inputs
    pd2g_regs dut_u (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pll1_fb_mode(fb_mode), .pll1_ref_above_8k(ref_fast),
        .pll2_fb_mode(fb_mode), .pll2_ref_above_8k(ref_fast),
        .pll1_auto_gain_select_en(pll1_auto),
        .pll1_analog_fb_gain(pll1_ana), .pll1_digital_fb_gain(pll1_dig),
        .pll2_auto_gain_select_en(pll2_auto),
        .pll2_analog_fb_gain(pll2_ana), .pll2_digital_fb_gain(pll2_dig),
        .pll1_applied_gain(pll1_gain), .pll1_gain_in_use(pll1_use),
        .pll2_applied_gain(pll2_gain), .pll2_gain_in_use(pll2_use)
    );

    // free-running clock
    initial clk = 1'b0;
    always #2 clk = ~clk;

    // one comparison, reported at once on mismatch
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // single write, strobe left high so writes can run back to back
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_rd    = 1'b0;
        reg_wr    = 1'b1;
        @(negedge clk);
    endtask : wr

    // single read, data checked one cycle after the strobe
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_wr   = 1'b0;
        reg_rd   = 1'b1;
        @(negedge clk);
        chk("reg_rdata", e, reg_rdata);
    endtask : rd

    // one cycle with both strobes low
    task automatic idle;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        @(negedge clk);
    endtask : idle

    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // watchdog against a hung run
    initial begin
        #100000;
        failures++;
        end_sim();
    end

    // main sequence
    initial begin
        failures  = 0;
        checks    = 0;
        reset     = 1'b1;
        reg_addr  = 7'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
        fb_mode   = PD2G_FB_DIGITAL;
        ref_fast  = 1'b0;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        // reset values and field outputs
        rd(7'h6C, 8'hC2);
        rd(7'h6D, 8'hC2);
        chk("pll2 fields", 8'hC2, pll2_fields);
        chk("pll1 fields", 8'hC2, pll1_fields);
        // all ones: unused bit reads zero, other register untouched
        wr(7'h6C, 8'hFF);
        rd(7'h6C, 8'hF7);
        rd(7'h6D, 8'hC2);
        // unmapped place: write ignored, read gives zero
        wr(7'h6E, 8'h00);
        rd(7'h6E, 8'h00);
        rd(7'h6C, 8'hF7);
        // read and write in one cycle: old value comes back
        reg_addr  = 7'h6D;
        reg_wdata = 8'h35;
        reg_wr    = 1'b1;
        reg_rd    = 1'b1;
        @(negedge clk);
        chk("reg_rdata", 8'hC2, reg_rdata);
        rd(7'h6D, 8'h35);
        // gain selection: off, digital mode, fast and slow analog
        for (int c = 0; c < 4; c++) begin
            wval     = (c == 0) ? 8'h53 : 8'hD3;
            fb_mode  = (c == 1) ? PD2G_FB_DIGITAL : PD2G_FB_ANALOG;
            ref_fast = (c != 3);
            exp_g    = (c == 2) ? 8'h05 : ((c == 3) ? 8'h00 : 8'h03);
            exp_u    = (c != 3);
            wr(7'h6C, wval);
            wr(7'h6D, wval);
            idle();
            chk("pll2 fields", wval, pll2_fields);
            chk("pll1 fields", wval, pll1_fields);
            chk("pll2 gain", exp_g, {5'h00, pll2_gain});
            chk("pll1 gain", exp_g, {5'h00, pll1_gain});
            chk("pll2 in use", {7'h00, exp_u}, {7'h00, pll2_use});
            chk("pll1 in use", {7'h00, exp_u}, {7'h00, pll1_use});
        end
        // first pll written alone: second pll gain must stay its own
        fb_mode = PD2G_FB_DIGITAL;
        wr(7'h6D, 8'hA1);
        idle();
        chk("pll1 gain", 8'h01, {5'h00, pll1_gain});
        chk("pll2 gain", 8'h03, {5'h00, pll2_gain});
        // second reset in mid-run restores defaults
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        rd(7'h6C, 8'hC2);
        rd(7'h6D, 8'hC2);
        end_sim();
    end
endmodule : pd2g_regs_tb
